// ==== hw/mac_statistics_counters.sv ====
// statistics counters of an ethernet mac: seven clear-on-read event
// counters, a control register, warning flag and a masked interrupt.
// assumes event inputs are synchronous one-cycle pulses and levels from the
// mac receive and transmit logic, and a master that never waits.
//
// Overview of operation
// R1: reading a counter returns its value and clears it to zero.
// R2: each counted event adds one to its counter without software.
// R3: errored packet counter counts every bad packet, incl. wire errors and overruns.
// R4: crc error counter adds one per received packet with failed crc and an even nibble count.
// R5: crc error counted at carrier drop with bad crc and even bytes.
// R6: missed packet counter adds one per reception aborted by fifo overrun.
// R7: alignment counter counts bad crc with odd nibble count.
// R8: symbol counter adds one per packet with rxer during rxdv.
// R9: oversize counter adds one per packet longer than 1518 bytes.
// R10: heartbeat counter adds one when no heartbeat follows a transmission.
// R11: warning flag sets on a counter warning, clears when counters clear.
// R12: freeze holds all counters and ignores events; resets to one.
// R13: writing one to clear-all zeroes every counter; reads as zero.
// R14: writing one to strobe adds one to all enabled counters; reads zero.
// R15: warning condition is all ones in a counter's top warning field.
// R16: an event during a clearing read leaves the counter at one.
`timescale 1ns/1ps

module stat_counter #(
  parameter int WIDTH = 8,
  parameter int WARN_BITS = 4
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_count,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_value,
  output logic o_warning
);

  initial begin
    if (WARN_BITS < 1 || WARN_BITS > WIDTH) begin
      $error("warning field does not fit the counter");
    end
  end

  // a clear never swallows an event in the same cycle, so clear lands on one
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_value <= '0;
    end else if (i_clear) begin
      o_value <= i_count ? WIDTH'(1) : '0; // R1 R13 R16
    end else if (i_count) begin
      o_value <= o_value + WIDTH'(1); // R2
    end
  end

  // counter rolls over freely; software is expected to poll on the warning
  assign o_warning = &o_value[WIDTH-1 -: WARN_BITS]; // R15

endmodule : stat_counter

module mac_statistics_counters
  import mac_statistics_pkg::*;
#(
  parameter int LENGTH_WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [mac_statistics_pkg::ADDR_WIDTH-1:0] i_address,
  input wire logic [mac_statistics_pkg::DATA_WIDTH-1:0] i_write_data,
  input wire logic i_write,
  input wire logic i_read,
  output logic [mac_statistics_pkg::DATA_WIDTH-1:0] o_read_data,
  input wire logic i_rxdv,
  input wire logic i_rxer,
  input wire logic i_rx_frame_done,
  input wire logic i_rx_crc_bad,
  input wire logic i_rx_odd_nibbles,
  input wire logic [LENGTH_WIDTH-1:0] i_rx_length,
  input wire logic i_rx_fifo_overrun,
  input wire logic i_tx_done,
  input wire logic i_tx_heartbeat_seen,
  output logic o_irq
);
  import mac_statistics_pkg::*;

  initial begin
    if (LENGTH_WIDTH < 11) begin
      $error("length port too narrow to see oversize frames");
    end
  end

  localparam logic [LENGTH_WIDTH-1:0] MAX_LENGTH = LENGTH_WIDTH'(MAX_FRAME_BYTES);

  logic freeze_control;
  logic overflow_warning_flag;
  logic clear_all_control;
  logic test_strobe_control;
  logic control_write;
  logic symbol_seen;
  logic symbol_now;
  logic oversize;
  logic [COUNTERS-1:0] event_hit;
  logic [COUNTERS-1:0] count_enable;
  logic [COUNTERS-1:0] clear_hit;
  logic [COUNTERS-1:0] warning;
  logic [COUNTERS-1:0] warning_q;
  logic [COUNTERS-1:0] warning_rise;
  logic [COUNTERS-1:0] irq_status;
  logic [COUNTERS-1:0] irq_mask;
  logic [VALUE_WIDTH-1:0] count_value [COUNTERS];
  logic [DATA_WIDTH-1:0] next_read_data;

  // control strobes act in the cycle of the write itself
  assign control_write = i_write && (i_address == OFFSET_CONTROL);
  assign clear_all_control = control_write && i_write_data[BIT_CLEAR_ALL]; // R13
  assign test_strobe_control = control_write && i_write_data[BIT_STROBE]; // R14

  // freeze bit; comes out of reset set so nothing counts before setup
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      freeze_control <= RESET_FREEZE; // R12
    end else if (control_write) begin
      freeze_control <= i_write_data[BIT_FREEZE]; // R12
    end
  end

  // a symbol error anywhere in the frame is remembered until its end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      symbol_seen <= 1'b0;
    end else if (i_rx_frame_done) begin
      symbol_seen <= 1'b0;
    end else if (i_rxdv && i_rxer) begin
      symbol_seen <= 1'b1; // R8
    end
  end

  // frame classification at carrier drop
  assign symbol_now = symbol_seen || (i_rxdv && i_rxer); // R8
  assign oversize = i_rx_length > MAX_LENGTH; // R9
  always_comb begin
    event_hit = '0;
    event_hit[IDX_CRC] = i_rx_frame_done && i_rx_crc_bad && !i_rx_odd_nibbles; // R4 R5
    event_hit[IDX_ALIGN] = i_rx_frame_done && i_rx_crc_bad && i_rx_odd_nibbles; // R7
    event_hit[IDX_SYMBOL] = i_rx_frame_done && symbol_now; // R8
    event_hit[IDX_OVERSIZE] = i_rx_frame_done && oversize; // R9
    event_hit[IDX_MISSED] = i_rx_fifo_overrun; // R6
    event_hit[IDX_HEARTBEAT] = i_tx_done && !i_tx_heartbeat_seen; // R10
    // overrun and frame end together still count as one bad packet
    event_hit[IDX_ERRORED] = i_rx_fifo_overrun ||
      (i_rx_frame_done && (i_rx_crc_bad || symbol_now || oversize)); // R3
  end

  // per-counter count and clear; strobe obeys freeze like real events
  always_comb begin
    for (int k = 0; k < COUNTERS; k++) begin
      count_enable[k] = (event_hit[k] || test_strobe_control) && !freeze_control; // R2 R12 R14
      clear_hit[k] = clear_all_control ||
        (i_read && (i_address == COUNT_OFFSET_TABLE[k])); // R1 R13
    end
  end

  genvar g;
  generate
    for (g = 0; g < COUNTERS; g++) begin : gen_counter
      logic [COUNT_WIDTH_TABLE[g]-1:0] value_slice;
      stat_counter #(
        .WIDTH(COUNT_WIDTH_TABLE[g]),
        .WARN_BITS(WARN_WIDTH_TABLE[g])
      ) u_counter (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_count(count_enable[g]),
        .i_clear(clear_hit[g]),
        .o_value(value_slice),
        .o_warning(warning[g])
      );
      assign count_value[g] = VALUE_WIDTH'(value_slice);
    end
  endgenerate

  // edge of each warning condition, used by the flag and the interrupt
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      warning_q <= '0;
    end else begin
      warning_q <= warning;
    end
  end
  assign warning_rise = warning & ~warning_q;

  // warning flag: a new warning wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      overflow_warning_flag <= 1'b0;
    end else if (|warning_rise) begin
      overflow_warning_flag <= 1'b1; // R11
    end else if (|clear_hit) begin
      overflow_warning_flag <= 1'b0; // R11
    end
  end

  // sticky interrupt status, write one to clear, new warnings win
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_status <= '0;
    end else if (i_write && (i_address == OFFSET_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~i_write_data[COUNTERS-1:0]) | warning_rise;
    end else begin
      irq_status <= irq_status | warning_rise;
    end
  end

  // interrupt mask
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_mask <= RESET_IRQ_MASK;
    end else if (i_write && (i_address == OFFSET_IRQ_MASK)) begin
      irq_mask <= i_write_data[COUNTERS-1:0];
    end
  end

  // registered interrupt output lags the status by one cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // read mux; unmapped addresses and strobe bits read as zero
  always_comb begin
    next_read_data = '0;
    if (i_address == OFFSET_CONTROL) begin
      next_read_data[BIT_WARNING] = overflow_warning_flag;
      next_read_data[BIT_FREEZE] = freeze_control;
    end else if (i_address == OFFSET_IRQ_STATUS) begin
      next_read_data[COUNTERS-1:0] = irq_status;
    end else if (i_address == OFFSET_IRQ_MASK) begin
      next_read_data[COUNTERS-1:0] = irq_mask;
    end
    for (int k = 0; k < COUNTERS; k++) begin
      if (i_address == COUNT_OFFSET_TABLE[k]) begin
        next_read_data[VALUE_WIDTH-1:0] = count_value[k]; // R1
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_read_data <= '0;
    end else if (i_read) begin
      o_read_data <= next_read_data;
    end else begin
      o_read_data <= '0;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  a_read_clears_count: assert property ( // R1
    i_read && i_address == OFFSET_CRC && !count_enable[IDX_CRC]
    |=> count_value[IDX_CRC] == 16'h0000)
    else $error("counter not cleared by its read");
  a_read_returns_value: assert property ( // R1
    i_read && i_address == OFFSET_CRC
    |=> o_read_data[VALUE_WIDTH-1:0] == $past(count_value[IDX_CRC]))
    else $error("read data is not the counter value");
  a_event_adds_one: assert property ( // R2
    count_enable[IDX_CRC] && !clear_hit[IDX_CRC]
    |=> count_value[IDX_CRC][7:0] == 8'($past(count_value[IDX_CRC][7:0]) + 8'h01))
    else $error("event did not add one");
  a_errored_overrun: assert property ( // R3
    i_rx_fifo_overrun && !freeze_control |-> count_enable[IDX_ERRORED])
    else $error("overrun not counted as errored packet");
  a_crc_even_bytes: assert property ( // R5
    i_rx_frame_done && i_rx_crc_bad && !freeze_control && !test_strobe_control
    |-> count_enable[IDX_CRC] != count_enable[IDX_ALIGN])
    else $error("bad crc not split by nibble parity");
  a_missed_overrun: assert property ( // R6
    i_rx_fifo_overrun && !freeze_control |-> count_enable[IDX_MISSED])
    else $error("overrun not counted as missed");
  a_align_odd: assert property ( // R7
    i_rx_frame_done && i_rx_crc_bad && i_rx_odd_nibbles && !freeze_control
    |-> count_enable[IDX_ALIGN] && !count_enable[IDX_CRC] || test_strobe_control)
    else $error("odd nibble bad crc not an alignment error");
  a_symbol_in_frame: assert property ( // R8
    i_rxdv && i_rxer && !i_rx_frame_done ##1 i_rx_frame_done && !freeze_control
    |-> count_enable[IDX_SYMBOL])
    else $error("symbol error lost before frame end");
  a_oversize_frame: assert property ( // R9
    i_rx_frame_done && !freeze_control
    |-> count_enable[IDX_OVERSIZE] == (oversize || test_strobe_control))
    else $error("oversize count wrong");
  a_heartbeat_loss: assert property ( // R10
    i_tx_done && !i_tx_heartbeat_seen && !freeze_control
    |-> count_enable[IDX_HEARTBEAT])
    else $error("missing heartbeat not counted");
  a_warning_flag_sets: assert property ( // R11
    |warning_rise |=> overflow_warning_flag)
    else $error("warning flag not set");
  a_freeze_holds: assert property ( // R12
    freeze_control && !(|clear_hit) |=> $stable(count_value[IDX_ERRORED]))
    else $error("frozen counter moved");
  a_clear_all_zero: assert property ( // R13
    clear_all_control && !count_enable[IDX_ERRORED] |=> count_value[IDX_ERRORED] == 16'h0000)
    else $error("clear-all left a count");
  a_strobe_all: assert property ( // R14
    test_strobe_control && !freeze_control |-> &count_enable)
    else $error("strobe missed a counter");
  a_read_event_one: assert property ( // R16
    clear_hit[IDX_CRC] && count_enable[IDX_CRC]
    |=> count_value[IDX_CRC] == 16'h0001)
    else $error("event lost in clearing read");
  // flag falls once a counter is cleared, unless a new warning arrives with it
  a_flag_clears: assert property ( // R11
    (|clear_hit) && !(|warning_rise) |=> !overflow_warning_flag)
    else $error("warning flag not cleared");
  a_crc_counts: assert property ( // R4
    i_rx_frame_done && i_rx_crc_bad && !i_rx_odd_nibbles && !freeze_control
    |-> count_enable[IDX_CRC])
    else $error("bad crc frame not counted");
  a_freeze_symbol: assert property ( // R12
    freeze_control && !clear_hit[IDX_SYMBOL] |=> $stable(count_value[IDX_SYMBOL]))
    else $error("frozen symbol counter moved");
  a_clear_all_last: assert property ( // R13
    clear_all_control && !count_enable[IDX_HEARTBEAT]
    |=> count_value[IDX_HEARTBEAT] == 16'h0000)
    else $error("clear-all left the heartbeat count");
  a_control_reads_zero: assert property ( // R13
    i_read && i_address == OFFSET_CONTROL
    |=> o_read_data[BIT_CLEAR_ALL] == 1'b0 && o_read_data[BIT_STROBE] == 1'b0)
    else $error("control strobe bits read back as one");
  a_irq_level: assert property ( // R15
    o_irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt does not follow masked status");

  c_read_nonzero: cover property (
    i_read && i_address == OFFSET_ERRORED && count_value[IDX_ERRORED] != 16'h0000);
  c_warning_irq: cover property (|warning_rise ##[1:3] o_irq);
  c_freeze_release: cover property (freeze_control ##1 !freeze_control);
  c_read_race: cover property (clear_hit[IDX_CRC] && count_enable[IDX_CRC]);
  c_symbol_late: cover property (i_rx_frame_done && symbol_seen);

endmodule : mac_statistics_counters

// ==== hw/mac_statistics_pkg.sv ====
// constants shared by the statistics counter block: register map, field
// positions, counter geometry and frame length limit.
// assumes a byte-addressed register port with 32-bit data words.
package mac_statistics_pkg;

  localparam int COUNTERS = 7;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int VALUE_WIDTH = 16;

  // counter indices
  localparam int IDX_ERRORED = 0;
  localparam int IDX_CRC = 1;
  localparam int IDX_MISSED = 2;
  localparam int IDX_ALIGN = 3;
  localparam int IDX_SYMBOL = 4;
  localparam int IDX_OVERSIZE = 5;
  localparam int IDX_HEARTBEAT = 6;

  // byte offsets of the counters, in index order
  localparam logic [ADDR_WIDTH-1:0] OFFSET_ERRORED = 8'h60;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_CRC = 8'h64;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_MISSED = 8'h68;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_ALIGN = 8'h6C;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_SYMBOL = 8'h70;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_OVERSIZE = 8'h74;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_HEARTBEAT = 8'h78;
  localparam logic [ADDR_WIDTH-1:0] COUNT_OFFSET_TABLE [COUNTERS] = '{
    OFFSET_ERRORED, OFFSET_CRC, OFFSET_MISSED, OFFSET_ALIGN,
    OFFSET_SYMBOL, OFFSET_OVERSIZE, OFFSET_HEARTBEAT};

  // counter widths and warning field widths, in index order
  localparam int COUNT_WIDTH_TABLE [COUNTERS] = '{16, 8, 8, 8, 8, 4, 4};
  localparam int WARN_WIDTH_TABLE [COUNTERS] = '{8, 4, 4, 4, 4, 2, 2};

  // control register and its fields
  localparam logic [ADDR_WIDTH-1:0] OFFSET_CONTROL = 8'h5C;
  localparam int BIT_WARNING = 0;
  localparam int BIT_FREEZE = 1;
  localparam int BIT_CLEAR_ALL = 2;
  localparam int BIT_STROBE = 3;
  localparam logic RESET_FREEZE = 1'b1;

  // interrupt status (write one to clear) and mask, one bit per counter
  localparam logic [ADDR_WIDTH-1:0] OFFSET_IRQ_STATUS = 8'hF0;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_IRQ_MASK = 8'hF4;
  localparam logic [COUNTERS-1:0] RESET_IRQ_MASK = 7'h00;

  // longest legal frame in bytes
  localparam int MAX_FRAME_BYTES = 1518;

endpackage : mac_statistics_pkg

// ==== verification/mac_event_model.sv ====
// far-side model: mac receive and transmit event logic feeding the counters.
// assumes one request per go pulse and at least one idle cycle between them.
`timescale 1ns/1ps

module mac_event_model (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_go,
  input wire logic [2:0] i_kind,
  input wire logic [15:0] i_length,
  output logic o_rxdv,
  output logic o_rxer,
  output logic o_frame_done,
  output logic o_crc_bad,
  output logic o_odd_nibbles,
  output logic [15:0] o_length,
  output logic o_overrun,
  output logic o_tx_done,
  output logic o_heartbeat_seen
);
  logic symbol_pending;
  logic [15:0] length_hold;

  // qualifiers toggle outside their strobe so a stale value is never counted
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_rxdv, o_rxer, o_frame_done, o_crc_bad, o_odd_nibbles} <= '0;
      {o_overrun, o_tx_done, o_heartbeat_seen, symbol_pending} <= '0;
      o_length <= 16'h0000;
      length_hold <= 16'h0000;
    end else begin
      {o_frame_done, o_overrun, o_tx_done, o_rxdv, symbol_pending} <= '0;
      o_rxer <= ~o_rxer; // noise outside rxdv must not count
      o_crc_bad <= ~o_crc_bad;
      o_odd_nibbles <= ~o_odd_nibbles;
      o_length <= ~o_length;
      o_heartbeat_seen <= ~o_heartbeat_seen;
      if (symbol_pending) begin
        o_frame_done <= 1'b1;
        o_crc_bad <= 1'b0;
        o_odd_nibbles <= 1'b0;
        o_length <= length_hold;
      end else if (i_go) begin
        case (i_kind)
          3'h3: begin
            o_rxdv <= 1'b1;
            o_rxer <= 1'b1;
            symbol_pending <= 1'b1;
            length_hold <= i_length;
          end
          3'h5: o_overrun <= 1'b1;
          3'h6, 3'h7: begin
            o_tx_done <= 1'b1;
            o_heartbeat_seen <= i_kind[0];
          end
          default: begin
            o_frame_done <= 1'b1;
            o_crc_bad <= (i_kind == 3'h1) || (i_kind == 3'h2);
            o_odd_nibbles <= (i_kind == 3'h2) || (i_kind == 3'h4);
            o_length <= i_length;
          end
        endcase
      end
    end
  end
endmodule : mac_event_model

// ==== verification/mac_statistics_counters_tb.sv ====
// self-checking bench for the statistics counters: register tasks, event model,
// expected-read queue. assumes the package constants and a one-cycle read.
`timescale 1ns/1ps

module mac_statistics_counters_tb;
  import mac_statistics_pkg::*;
  logic i_clock, i_arst_n, i_write, i_read, go, rd_d, frozen;
  logic [7:0] i_address;
  logic [31:0] i_write_data, expq[$];
  logic [2:0] kind;
  logic [15:0] len, lfsr, rlen;
  logic rxdv, rxer, fdone, crc, odd, ovr, txd, hb, irq;
  logic [31:0] rdata;
  int err_count, cmp_count, cnt[COUNTERS];

  mac_statistics_counters u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_address(i_address), .i_write_data(i_write_data), .i_write(i_write),
    .i_read(i_read), .o_read_data(rdata), .i_rxdv(rxdv), .i_rxer(rxer),
    .i_rx_frame_done(fdone), .i_rx_crc_bad(crc), .i_rx_odd_nibbles(odd),
    .i_rx_length(rlen), .i_rx_fifo_overrun(ovr), .i_tx_done(txd),
    .i_tx_heartbeat_seen(hb), .o_irq(irq));
  mac_event_model u_mac (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_go(go),
    .i_kind(kind), .i_length(len), .o_rxdv(rxdv), .o_rxer(rxer), .o_frame_done(fdone),
    .o_crc_bad(crc), .o_odd_nibbles(odd), .o_length(rlen), .o_overrun(ovr),
    .o_tx_done(txd), .o_heartbeat_seen(hb));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // expected counter effect of one event, nothing while frozen
  function automatic void apply(input int k, input int l);
    bit fr;
    bit big;
    fr = (k <= 4);
    big = fr && (l > MAX_FRAME_BYTES);
    if (frozen) return;
    if (k == 1) cnt[IDX_CRC]++;
    if (k == 2) cnt[IDX_ALIGN]++;
    if (k == 3) cnt[IDX_SYMBOL]++;
    if (big) cnt[IDX_OVERSIZE]++;
    if (k == 5) cnt[IDX_MISSED]++;
    if (k == 6) cnt[IDX_HEARTBEAT]++;
    if (k == 5 || (fr && (big || (k >= 1 && k <= 3)))) cnt[IDX_ERRORED]++;
  endfunction : apply

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_address <= a;
    i_write_data <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_address <= a;
    expq.push_back(exp);
    @(posedge i_clock);
    i_read <= 1'b0;
  endtask : rd

  task automatic ev(input int k, input int l);
    @(posedge i_clock);
    go <= 1'b1;
    kind <= 3'(k);
    len <= 16'(l);
    apply(k, l);
    @(posedge i_clock);
    go <= 1'b0;
  endtask : ev

  // read every counter, expecting the model value, then the model clears
  task automatic rd_all;
    repeat (4) @(posedge i_clock);
    for (int i = 0; i < COUNTERS; i++) begin
      rd(COUNT_OFFSET_TABLE[i], 32'(cnt[i] % (1 << COUNT_WIDTH_TABLE[i])));
      cnt[i] = 0;
    end
  endtask : rd_all

  task automatic strobe;
    wr(OFFSET_CONTROL, 32'h0000_0008);
    foreach (cnt[i]) cnt[i]++;
  endtask : strobe

  // read data stands only in the cycle after the strobe
  always @(posedge i_clock) rd_d <= i_read;
  always @(negedge i_clock) begin
    if (rd_d) begin
      if (expq.size() == 0) check(rdata, 32'hFFFF_FFFF);
      else check(rdata, expq.pop_front());
    end else if (i_arst_n) begin
      check(rdata, 32'h0000_0000);
    end
  end

  initial begin
    repeat (30000) @(posedge i_clock);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end

  initial begin
    {i_arst_n, i_write, i_read, go} = '0;
    {i_address, i_write_data, kind, len} = '0;
    lfsr = 16'h0628;
    frozen = 1'b1;
    repeat (20) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(OFFSET_CONTROL, 32'h0000_0002);
    rd(OFFSET_IRQ_MASK, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    ev(1, 64);
    rd_all();
    $display("reset and freeze test done");
    wr(OFFSET_CONTROL, 32'h0000_0000);
    frozen = 1'b0;
    for (int k = 0; k < 8; k++) ev(k, 1518);
    ev(0, 1519);
    ev(3, 2000);
    rd_all();
    repeat (40) begin
      lfsr = lfsr_next(lfsr);
      ev(lfsr[2:0], lfsr[15] ? 1519 + lfsr[5:0] : 64 + lfsr[9:0]);
    end
    rd_all();
    $display("event kinds test done");
    // an event landing on a clearing read must survive it
    ev(1, 64);
    repeat (3) @(posedge i_clock);
    go <= 1'b1;
    kind <= 3'h1;
    len <= 16'h0040;
    @(posedge i_clock);
    go <= 1'b0;
    i_read <= 1'b1;
    i_address <= OFFSET_CRC;
    expq.push_back(32'h0000_0001);
    @(posedge i_clock);
    i_read <= 1'b0;
    cnt[IDX_CRC] = 1;
    cnt[IDX_ERRORED]++;
    rd_all();
    $display("read race test done");
    ev(5, 0);
    ev(6, 0);
    wr(OFFSET_CONTROL, 32'h0000_0004);
    foreach (cnt[i]) cnt[i] = 0;
    rd(OFFSET_CONTROL, 32'h0000_0000);
    rd_all();
    strobe();
    rd(OFFSET_CONTROL, 32'h0000_0000);
    rd_all();
    wr(OFFSET_CONTROL, 32'h0000_0002);
    wr(OFFSET_CONTROL, 32'h0000_000A);
    rd_all();
    wr(OFFSET_CONTROL, 32'h0000_0000);
    $display("clear and strobe test done");
    wr(OFFSET_IRQ_STATUS, 32'h0000_007F);
    wr(OFFSET_IRQ_MASK, 32'h0000_0020);
    repeat (12) strobe();
    repeat (3) @(posedge i_clock);
    check(irq, 1'b1);
    rd(OFFSET_IRQ_STATUS, 32'h0000_0060);
    rd(OFFSET_CONTROL, 32'h0000_0001);
    wr(OFFSET_IRQ_STATUS, 32'h0000_0020);
    repeat (3) @(posedge i_clock);
    check(irq, 1'b0);
    rd(OFFSET_IRQ_STATUS, 32'h0000_0040);
    rd_all();
    rd(OFFSET_CONTROL, 32'h0000_0000);
    repeat (3) @(posedge i_clock);
    $display("warning and interrupt test done");
    results();
  end
endmodule : mac_statistics_counters_tb
